// File: verilog/scs_pkg.sv
/*
 * Constants for the shutdown and clock select block: register index,
 * field positions, reset values and clock rate codes.
 * Assumes a plain register port with 16-bit word indexes.
 */
`default_nettype none
package scs_pkg;
   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [15:0] ENABLE_AND_CLOCK_CONFIG = 16'h0521; // Register index
   localparam logic [15:0] STATUS_REG              = 16'h0522; // Read-only state view
   localparam logic [31:0] CFG_RESET               = 32'h0000_0000;
   localparam logic [31:0] CFG_WRITE_MASK          = 32'h0000_5f07; // Bits 14,12,11:8,2:0

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int RUN_ENABLE_BIT   = 0;
   localparam int SW_SHUTDOWN_BIT  = 1;
   localparam int PULSE_MODE_BIT   = 2;
   localparam int RATE_LSB         = 8;
   localparam int CLK_SRC_BIT      = 11;
   localparam int OSC_SELECT_BIT   = 12;
   localparam int OSC_STOP_BIT     = 14;

   // ==========================================================
   // Clock rate codes (1.536 to 24.576 MHz)
   // ==========================================================
   localparam logic [2:0] RATE_1M536  = 3'h0;
   localparam logic [2:0] RATE_3M072  = 3'h1;
   localparam logic [2:0] RATE_6M144  = 3'h2;
   localparam logic [2:0] RATE_12M288 = 3'h3;
   localparam logic [2:0] RATE_24M576 = 3'h4;
   localparam logic [2:0] RATE_MAX    = 3'h4;

   // Initial pulse-mode state after reset: enabled
   localparam logic       TOGGLE_RESET = 1'b1;
   // Synchroniser reset value: the pin's idle (run) level
   localparam logic       PIN_IDLE     = 1'b1;
endpackage : scs_pkg
`default_nettype wire

// File: verilog/scs_shutdown_clock_select.sv
/*
 * Shutdown control and reference clock selection.
 * Assumes a single 100 MHz clock, a host register port with one-cycle
 * strobes, and an asynchronous shutdown pin from the board.
 */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module scs_shutdown_clock_select
   import scs_pkg::*;
(
   input  wire logic        clk,            // 100 MHz system clock
   input  wire logic        rstn,           // Async reset, active low
   input  wire logic [15:0] reg_addr,       // Register index
   input  wire logic [31:0] reg_wdata,      // Write data
   input  wire logic        reg_wr,         // Write strobe
   input  wire logic        reg_rd,         // Read strobe
   output logic      [31:0] reg_rdata,      // Read data, cycle after strobe
   input  wire logic        shutdown_n_pin, // Board shutdown line
   output logic             device_enable,  // Device running
   output logic             ref_clk_sel,    // 0 master clock, 1 bit clock
   output logic      [2:0]  ref_clk_rate,   // Reference rate code
   output logic             power_mgmt_osc_run // Oscillator running
);

   // ==========================================================
   // Configuration register
   // ==========================================================
   logic [31:0] cfg;          // Survives every shutdown
   logic        pin_meta;     // First synchroniser stage
   logic        pin_sync;     // Second synchroniser stage
   logic        pin_prev;     // Previous synchronised level
   logic        toggle_state; // Pulse-mode enable state

   // Decode: hits, strobes and the next values of the registered outputs.
   // Rate codes 5 to 7 pass through unchecked; the host owns that choice.
   wire         cfg_hit      = (reg_addr == ENABLE_AND_CLOCK_CONFIG);
   wire         stat_hit     = (reg_addr == STATUS_REG);
   wire         cfg_we       = reg_wr && cfg_hit;
   wire         pin_rise     = pin_sync && !pin_prev;
   wire         sw_mode      = cfg[SW_SHUTDOWN_BIT];
   wire         pulse_mode   = cfg[PULSE_MODE_BIT];
   wire [31:0]  stat_word    = {28'h0000000, power_mgmt_osc_run, ref_clk_sel,
                                toggle_state, device_enable};
   wire [31:0]  next_rdata   = cfg_hit ? cfg : (stat_hit ? stat_word : 32'h0000_0000);
   wire         next_enable  = sw_mode ? cfg[RUN_ENABLE_BIT]
                             : (pulse_mode ? toggle_state : pin_sync);
   wire         next_osc_run = !(cfg[OSC_SELECT_BIT] && cfg[OSC_STOP_BIT]);

   // Register write; only shutdown-independent host writes change it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg <= CFG_RESET;
      end else if (cfg_we) begin
         cfg <= reg_wdata & CFG_WRITE_MASK;
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Shutdown pin synchroniser and edge detect
   // ==========================================================
   // Two stages so one bounce-free edge gives exactly one toggle.
   // Stages reset to the pin's idle level, so a pulse-mode write right after
   // reset never sees a false rising edge; the trade-off is that with the pin
   // held low the enable shows high for two cycles until the stages fill.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= PIN_IDLE;
         pin_sync <= PIN_IDLE;
         pin_prev <= PIN_IDLE;
      end else begin
         pin_meta <= shutdown_n_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Pulse-mode state flips on each rising edge; held in other modes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         toggle_state <= TOGGLE_RESET;
      end else if (!sw_mode && pulse_mode && pin_rise) begin
         toggle_state <= !toggle_state;
      end
   end

   // ==========================================================
   // Outputs, all registered
   // ==========================================================
   // Rate and source feed the clock tree that every engine uses
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         device_enable      <= 1'b0;
         ref_clk_sel        <= 1'b0;
         ref_clk_rate       <= RATE_1M536;
         power_mgmt_osc_run <= 1'b1;
      end else begin
         device_enable      <= next_enable;
         ref_clk_sel        <= cfg[CLK_SRC_BIT];
         ref_clk_rate       <= cfg[RATE_LSB +: 3];
         power_mgmt_osc_run <= next_osc_run;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   // Checks that look back across a reset release start only once rstn was
   // high at a full edge: the flops still see reset at the releasing edge
   // while the disable condition already reads high there.

   // Registered source follows the stored source bit one edge later
   property p_src;
      @(posedge clk) disable iff (!rstn) 1'b1 ##1 ref_clk_sel == $past(cfg[CLK_SRC_BIT]);
   endproperty
   a_src: assert property (p_src) else $error("clock source mismatch");

   // A written rate code reaches the clock tree two edges later
   property p_rate;
      @(posedge clk) disable iff (!rstn) cfg_we |-> ##2 ref_clk_rate == $past(reg_wdata[RATE_LSB +: 3], 2);
   endproperty
   a_rate: assert property (p_rate) else $error("rate not applied");

   // Three settled level-mode cycles: enable copies the synchronised pin
   property p_hw_level;
      @(posedge clk) disable iff (!rstn)
         (!sw_mode && !pulse_mode) [*3] |-> device_enable == $past(pin_sync);
   endproperty
   a_hw_level: assert property (p_hw_level) else $error("level mode wrong");

   // A pulse-mode rising edge flips the stored state
   property p_pulse;
      @(posedge clk) disable iff (!rstn)
         (!sw_mode && pulse_mode && pin_rise) |=> toggle_state != $past(toggle_state);
   endproperty
   a_pulse: assert property (p_pulse) else $error("no toggle on edge");

   // Without a pulse-mode rising edge the stored state holds
   property p_hold;
      @(posedge clk) disable iff (!rstn)
         !(!sw_mode && pulse_mode && pin_rise) |=> $stable(toggle_state);
   endproperty
   a_hold: assert property (p_hold) else $error("toggle without edge");

   // Software mode: the run-enable bit alone decides
   property p_sw;
      @(posedge clk) disable iff (!rstn) sw_mode |=> device_enable == $past(cfg[RUN_ENABLE_BIT]);
   endproperty
   a_sw: assert property (p_sw) else $error("software mode wrong");

   // Only a host write may change the configuration
   property p_keep;
      @(posedge clk) disable iff (!rstn) !cfg_we |=> $stable(cfg);
   endproperty
   a_keep: assert property (p_keep) else $error("config changed");

   // A read of the configuration returns the stored word
   property p_readback;
      @(posedge clk) disable iff (!rstn)
         (reg_rd && cfg_hit) |=> reg_rdata == $past(cfg);
   endproperty
   a_readback: assert property (p_readback) else $error("config readback wrong");

   // Read data stands for one cycle only, zero when no read was made
   property p_rd_idle;
      @(posedge clk) disable iff (!rstn) !reg_rd |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stale read data");

   // Both oscillator bits set stop it
   property p_osc;
      @(posedge clk) disable iff (!rstn)
         (cfg[OSC_SELECT_BIT] && cfg[OSC_STOP_BIT]) |=> !power_mgmt_osc_run;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator not stopped");

   // Either oscillator bit clear keeps it running
   property p_osc_run;
      @(posedge clk) disable iff (!rstn)
         !(cfg[OSC_SELECT_BIT] && cfg[OSC_STOP_BIT]) |=> power_mgmt_osc_run;
   endproperty
   a_osc_run: assert property (p_osc_run) else $error("oscillator stopped early");

   // Synchroniser depth: the pin shows two edges later
   property p_sync;
      @(posedge clk) disable iff (!rstn) $past(rstn) |-> ##2 pin_sync == $past(shutdown_n_pin, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sync depth wrong");

   // Pin control: enable follows the pulse state or the pin level
   property p_hwdef;
      @(posedge clk) disable iff (!rstn) ($past(rstn) && !sw_mode) |=>
         device_enable == ($past(pulse_mode) ? $past(toggle_state) : $past(pin_sync));
   endproperty
   a_hwdef: assert property (p_hwdef) else $error("pin mode wrong");

   // Main scenarios
   c_pulse_toggle: cover property (@(posedge clk) disable iff (!rstn) pulse_mode && pin_rise);
   c_sw_off:       cover property (@(posedge clk) disable iff (!rstn) sw_mode && !device_enable);
   c_osc_stop:     cover property (@(posedge clk) disable iff (!rstn) !power_mgmt_osc_run);
   c_bitclk:       cover property (@(posedge clk) disable iff (!rstn) ref_clk_sel);
   c_level_off:    cover property (@(posedge clk) disable iff (!rstn) !sw_mode && !pulse_mode && !device_enable);

endmodule : scs_shutdown_clock_select
`default_nettype wire

// File: dv/scs_board_line.sv
/* Board-side model of the shutdown line.
   Assumes the bench asks for a level just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Board shutdown line
// ==========================================
module scs_board_line (
   input  wire logic clk,                   // System clock
   input  wire logic level,                 // Wanted pin level
   output var  logic shutdown_n_pin = 1'b1  // Pin into the device, high at power-up
);
   // Registered so the pin never glitches between edges
   always @(posedge clk) begin
      shutdown_n_pin <= level;
   end
endmodule : scs_board_line
`default_nettype wire

// File: dv/scs_shutdown_clock_select_tb_top.sv
/* Self-checking bench for the shutdown and clock select block.
   Assumes one 100 MHz clock and the one-cycle register strobes. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench top
// ==========================================
module scs_shutdown_clock_select_tb_top;
   import scs_pkg::*;
   logic        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, level = 1; // Bench drives
   logic [15:0] reg_addr = 16'h0000;                              // Register index
   logic [31:0] reg_wdata = 32'h0000_0000, rd;                    // Write data, read capture
   wire  logic [31:0] reg_rdata;                                  // Read data
   wire  logic [2:0]  rate;                                       // Rate code out
   wire  logic        pin, en, sel, osc;                          // Design outputs
   int          fail_count = 0, checked = 0;                      // Tallies
   always #5 clk = ~clk;
   scs_board_line board (.clk(clk), .level(level), .shutdown_n_pin(pin));
   scs_shutdown_clock_select dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .shutdown_n_pin(pin), .device_enable(en), .ref_clk_sel(sel), .ref_clk_rate(rate),
      .power_mgmt_osc_run(osc));
   // Compare one value, four-state exact
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One-cycle write, then let outputs settle
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : wr
   // One-cycle read; data stands only in the following cycle
   task rdr(input logic [15:0] a);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask : rdr
   // Move the board line, wait past the two-stage sync
   task pin_to(input logic v);
      @(posedge clk) level <= v;
      repeat (6) @(posedge clk);
      #1;
   endtask : pin_to
   task wrap_up;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   // Watchdog: tests take about 1.8 us
   initial begin
      #50us;
      fail_count++;
      wrap_up();
   end
   // ==========================================
   // Test sequence
   // ==========================================
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check(32'(en), 32'h1);
      rdr(ENABLE_AND_CLOCK_CONFIG); check(rd, CFG_RESET);
      pin_to(1'b0); check(32'(en), 32'h0);
      pin_to(1'b1); check(32'(en), 32'h1);
      // Rate codes 0 to 4, alternating the source
      for (int r = 0; r < 5; r++) begin
         wr(ENABLE_AND_CLOCK_CONFIG, (32'(r) << RATE_LSB) | (32'(r % 2) << CLK_SRC_BIT));
         check(32'(sel), 32'(r % 2));
         check(32'(rate), 32'(r));
      end
      // Host takes the slower bit clock when both are present
      wr(ENABLE_AND_CLOCK_CONFIG, 32'h0000_0800); check(32'({sel, rate}), 32'h8);
      // Software mode ignores the pin
      wr(ENABLE_AND_CLOCK_CONFIG, 32'h0000_0002); check(32'(en), 32'h0);
      wr(ENABLE_AND_CLOCK_CONFIG, 32'h0000_0003); check(32'(en), 32'h1);
      pin_to(1'b0); check(32'(en), 32'h1);
      pin_to(1'b1);
      // Pulse mode: only rising edges toggle, one change each
      wr(ENABLE_AND_CLOCK_CONFIG, 32'h0000_0004); check(32'(en), 32'h1);
      pin_to(1'b0); check(32'(en), 32'h1);
      pin_to(1'b1); check(32'(en), 32'h0);
      pin_to(1'b0);
      pin_to(1'b1); check(32'(en), 32'h1);
      // Oscillator stops only with both bits
      wr(ENABLE_AND_CLOCK_CONFIG, 32'h0000_1000); check(32'(osc), 32'h1);
      wr(ENABLE_AND_CLOCK_CONFIG, 32'h0000_5000); check(32'(osc), 32'h0);
      // Shutdown keeps the configuration
      pin_to(1'b0); check(32'(en), 32'h0);
      rdr(ENABLE_AND_CLOCK_CONFIG); check(rd, 32'h0000_5000);
      rdr(16'h0520); check(rd, 32'h0000_0000);        // Unmapped index reads zero
      rdr(STATUS_REG); check(rd, 32'h0000_0002);      // Stopped, pulse state kept, osc off
      // Mid-run reset with the pin high, then pulse mode at once: no false edge
      pin_to(1'b1);
      @(posedge clk) rstn <= 1'b0;
      repeat (15) @(posedge clk);
      #1;
      check(32'({osc, en, sel, rate}), 32'h20);       // Reset values of the outputs
      @(posedge clk) rstn <= 1'b1;
      wr(ENABLE_AND_CLOCK_CONFIG, 32'h0000_0004); check(32'(en), 32'h1);
      wrap_up();
   end
endmodule : scs_shutdown_clock_select_tb_top
`default_nettype wire
